//--- rtl/jsr_consts.svh
/*
  Register offsets, control field positions and reset values of the
  joystick sensor register bank.
  Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef JSR_CONSTS_SVH
`define JSR_CONSTS_SVH

// byte addresses
`define JSR_ADDR_MAKER 8'h0c
`define JSR_ADDR_VERSION 8'h0d
`define JSR_ADDR_SIREV 8'h0e
`define JSR_ADDR_CTRL 8'h0f
`define JSR_ADDR_X_RES 8'h10
`define JSR_ADDR_Y_RES 8'h11
`define JSR_ADDR_POS_X 8'h12
`define JSR_ADDR_NEG_X 8'h13
`define JSR_ADDR_POS_Y 8'h14
`define JSR_ADDR_NEG_Y 8'h15
`define JSR_ADDR_CH4M_HI 8'h16
`define JSR_ADDR_CH4M_LO 8'h17
`define JSR_ADDR_CH4P_HI 8'h18
`define JSR_ADDR_CH4P_LO 8'h19

// main_control field positions
`define JSR_CTRL_IDLE 7
`define JSR_CTRL_TB_HI 6
`define JSR_CTRL_TB_LO 4
`define JSR_CTRL_MASK 3
`define JSR_CTRL_COND 2
`define JSR_CTRL_SRST 1
`define JSR_CTRL_VALID 0

// reset values
`define JSR_RST_IDLE 1'b1
`define JSR_RST_TIMEBASE 3'h7
`define JSR_RST_MASK 1'b0
`define JSR_RST_COND 1'b0
`define JSR_RST_RESULT 8'h00
`define JSR_RST_POS_THR 8'h05
`define JSR_RST_NEG_THR 8'hfb
`define JSR_RST_VOLT 12'h000
`define JSR_UNMAPPED_READ 8'h00

`endif

//--- rtl/jsr_pkg.sv
/*
  Types shared by the joystick sensor register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package jsr_pkg;
  typedef logic signed [7:0] jsr_coord_t;
  typedef logic signed [11:0] jsr_volt_t;
  typedef enum logic [3:0] {
    JSR_IDLE = 4'h0,
    JSR_ADDR = 4'h1,
    JSR_ADDR_ACK = 4'h2,
    JSR_REG = 4'h3,
    JSR_REG_ACK = 4'h4,
    JSR_WR = 4'h5,
    JSR_WR_ACK = 4'h6,
    JSR_RD = 4'h7,
    JSR_RD_ACK = 4'h8
  } jsr_i2c_state_t;
endpackage : jsr_pkg

//--- rtl/jsr_sync2.sv
/*
  Two-flop synchroniser for the serial bus pins.
  Assumes inputs asynchronous to i_core_clk; first stage feeds only the second.
*/
`timescale 1ns/10ps
module jsr_sync2 (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pins in, synchronised out
  input wire logic [1:0] i_async,
  output logic [1:0] o_sync
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      // idle bus level is high, so reset to one
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;
endmodule : jsr_sync2

//--- rtl/jsr_window_cmp.sv
/*
  Signed comparison of a coordinate pair against four wake-up thresholds.
  Assumes thresholds and coordinates are two's complement bytes.
*/
`timescale 1ns/10ps
module jsr_window_cmp (
  // coordinates
  input wire jsr_pkg::jsr_coord_t i_x,
  input wire jsr_pkg::jsr_coord_t i_y,
  // thresholds
  input wire jsr_pkg::jsr_coord_t i_pos_x,
  input wire jsr_pkg::jsr_coord_t i_neg_x,
  input wire jsr_pkg::jsr_coord_t i_pos_y,
  input wire jsr_pkg::jsr_coord_t i_neg_y,
  // result
  output logic o_outside
);
  import jsr_pkg::*;

  // a point on a threshold still counts as inside
  assign o_outside = (i_x > i_pos_x) || (i_x < i_neg_x) ||
                     (i_y > i_pos_y) || (i_y < i_neg_y);
endmodule : jsr_window_cmp

//--- rtl/jsr_register_bank.sv
/*
  Joystick sensor register bank with its serial two-wire slave port.
  Assumes the measurement engine runs on i_core_clk and pulses i_xy_new
  when a coordinate pair and channel voltages are valid on its outputs.
*/
// Functional notes
// - every register is reached over the two-wire bus by its byte address
// - control bit 7 selects idle mode at 1, low power at 0; resets 1
// - control bits 6..4 set the low power readout time base; reset 111
// - control bit 3 at 1 disables the interrupt; reset 0, enabled
// - condition bit 0: interrupt goes low on every new coordinate pair
// - condition bit 1: interrupt only on new pair outside threshold window
// - writing 1 to control bit 1 returns all registers to reset values
// - control bit 0 reads 0 while calculating, 1 when coordinates ready
// - X at 10h and Y at 11h, read-only signed bytes, reset zero
// - reading the Y result clears the pending interrupt
// - four writable signed thresholds; positive reset 5, negative minus 5
// - channel voltages are 12-bit signed, high nibble sign-extended, low byte next
// - three read-only identification bytes: maker, version, revision
`timescale 1ns/10ps
`include "jsr_consts.svh"
module jsr_register_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary bus address
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] VERSION_ID = 8'h21, // arbitrary value
  parameter logic [7:0] SIREV_ID = 8'h03 // arbitrary value
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // two-wire serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // measurement engine
  input wire logic i_xy_new,
  input wire logic i_calc_start,
  input wire jsr_pkg::jsr_coord_t i_x_coord,
  input wire jsr_pkg::jsr_coord_t i_y_coord,
  input wire jsr_pkg::jsr_volt_t i_ch4_minus,
  input wire jsr_pkg::jsr_volt_t i_ch4_plus,
  // control and interrupt
  output logic o_idle_mode,
  output logic [2:0] o_timebase,
  output logic o_motion_irq_n
);
  import jsr_pkg::*;

  // bus engine state
  jsr_i2c_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic acked_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic scl_d_q;
  logic sda_d_q;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;

  // register file
  logic idle_q;
  logic [2:0] tb_q;
  logic mask_q;
  logic cond_q;
  logic valid_q;
  logic irq_n_q;
  jsr_coord_t x_res_q;
  jsr_coord_t y_res_q;
  jsr_coord_t pos_x_q;
  jsr_coord_t neg_x_q;
  jsr_coord_t pos_y_q;
  jsr_coord_t neg_y_q;
  jsr_volt_t ch4m_q;
  jsr_volt_t ch4p_q;

  jsr_sync2 u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // bus events
  logic scl_rise_w, scl_fall_w, start_w, stop_w;
  logic byte_full_w, in_byte_w, rd_load_w, wr_stb_w;
  assign scl_rise_w = scl_s & ~scl_d_q;
  assign scl_fall_w = ~scl_s & scl_d_q;
  assign start_w = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_w = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign byte_full_w = (cnt_q == 4'h8);
  assign in_byte_w = (state_q == JSR_ADDR) || (state_q == JSR_REG) ||
                     (state_q == JSR_WR) || (state_q == JSR_RD);
  assign rd_load_w = scl_fall_w && ((state_q == JSR_ADDR_ACK && rw_q) ||
                                    (state_q == JSR_RD_ACK && acked_q));
  assign wr_stb_w = scl_fall_w && state_q == JSR_WR && byte_full_w;

  // write decode
  logic soft_w, bank_rst_w, wr_ctrl_w;
  assign wr_ctrl_w = wr_stb_w && ptr_q == `JSR_ADDR_CTRL;
  assign soft_w = wr_ctrl_w && sh_q[`JSR_CTRL_SRST];
  assign bank_rst_w = i_rst || soft_w;

  // read mux; unmapped bytes read as zero
  logic [7:0] rd_byte_w;
  logic [7:0] ctrl_rd_w;
  assign ctrl_rd_w = {idle_q, tb_q, mask_q, cond_q, 1'b0, valid_q};
  assign rd_byte_w =
    (ptr_q == `JSR_ADDR_MAKER)   ? MAKER_ID :
    (ptr_q == `JSR_ADDR_VERSION) ? VERSION_ID :
    (ptr_q == `JSR_ADDR_SIREV)   ? SIREV_ID :
    (ptr_q == `JSR_ADDR_CTRL)    ? ctrl_rd_w :
    (ptr_q == `JSR_ADDR_X_RES)   ? x_res_q :
    (ptr_q == `JSR_ADDR_Y_RES)   ? y_res_q :
    (ptr_q == `JSR_ADDR_POS_X)   ? pos_x_q :
    (ptr_q == `JSR_ADDR_NEG_X)   ? neg_x_q :
    (ptr_q == `JSR_ADDR_POS_Y)   ? pos_y_q :
    (ptr_q == `JSR_ADDR_NEG_Y)   ? neg_y_q :
    (ptr_q == `JSR_ADDR_CH4M_HI) ? {{4{ch4m_q[11]}}, ch4m_q[11:8]} :
    (ptr_q == `JSR_ADDR_CH4M_LO) ? ch4m_q[7:0] :
    (ptr_q == `JSR_ADDR_CH4P_HI) ? {{4{ch4p_q[11]}}, ch4p_q[11:8]} :
    (ptr_q == `JSR_ADDR_CH4P_LO) ? ch4p_q[7:0] :
    `JSR_UNMAPPED_READ;

  // interrupt decision
  logic outside_w, rd_y_w, irq_set_w, irq_clr_w;
  jsr_window_cmp u_window (
    .i_x(i_x_coord),
    .i_y(i_y_coord),
    .i_pos_x(pos_x_q),
    .i_neg_x(neg_x_q),
    .i_pos_y(pos_y_q),
    .i_neg_y(neg_y_q),
    .o_outside(outside_w)
  );
  assign rd_y_w = rd_load_w && ptr_q == `JSR_ADDR_Y_RES;
  assign irq_set_w = i_xy_new && !mask_q && (!cond_q || outside_w);
  assign irq_clr_w = rd_y_w || mask_q;

  // pin edge history and the open-drain data level
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      sda_out_q <= 1'b0;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
      sda_out_q <= 1'b0;
    end
  end

  // byte engine: sample on rising clock, change data after falling clock
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= JSR_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      acked_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_w) begin
      state_q <= JSR_ADDR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_w) begin
      state_q <= JSR_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise_w) begin
      if (state_q == JSR_RD_ACK) begin
        acked_q <= ~sda_s;
      end else if (in_byte_w) begin
        sh_q <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end
    end else if (scl_fall_w) begin
      unique case (state_q)
        JSR_IDLE: begin
        end
        JSR_ADDR: begin
          if (byte_full_w) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              rw_q <= sh_q[0];
              sda_oe_q <= 1'b1;
              state_q <= JSR_ADDR_ACK;
            end else begin
              state_q <= JSR_IDLE;
            end
          end
        end
        JSR_ADDR_ACK, JSR_RD_ACK: begin
          cnt_q <= 4'h0;
          if (rd_load_w) begin
            tx_q <= rd_byte_w;
            sda_oe_q <= ~rd_byte_w[7];
            ptr_q <= ptr_q + 8'h01;
            state_q <= JSR_RD;
          end else if (state_q == JSR_ADDR_ACK) begin
            sda_oe_q <= 1'b0;
            state_q <= JSR_REG;
          end else begin
            // host refused more data: wait for stop
            sda_oe_q <= 1'b0;
            state_q <= JSR_IDLE;
          end
        end
        JSR_REG: begin
          if (byte_full_w) begin
            ptr_q <= sh_q;
            sda_oe_q <= 1'b1;
            state_q <= JSR_REG_ACK;
          end
        end
        JSR_REG_ACK, JSR_WR_ACK: begin
          cnt_q <= 4'h0;
          sda_oe_q <= 1'b0;
          state_q <= JSR_WR;
        end
        JSR_WR: begin
          if (byte_full_w) begin
            ptr_q <= ptr_q + 8'h01;
            sda_oe_q <= 1'b1;
            state_q <= JSR_WR_ACK;
          end
        end
        JSR_RD: begin
          if (byte_full_w) begin
            sda_oe_q <= 1'b0;
            state_q <= JSR_RD_ACK;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_q <= ~tx_q[6];
          end
        end
        default: begin
          state_q <= JSR_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // main_control fields
  always_ff @(posedge i_core_clk) begin
    if (bank_rst_w) begin
      idle_q <= `JSR_RST_IDLE;
      tb_q <= `JSR_RST_TIMEBASE;
      mask_q <= `JSR_RST_MASK;
      cond_q <= `JSR_RST_COND;
    end else if (wr_ctrl_w) begin
      idle_q <= sh_q[`JSR_CTRL_IDLE];
      tb_q <= sh_q[`JSR_CTRL_TB_HI:`JSR_CTRL_TB_LO];
      mask_q <= sh_q[`JSR_CTRL_MASK];
      cond_q <= sh_q[`JSR_CTRL_COND];
    end
  end

  // thresholds
  always_ff @(posedge i_core_clk) begin
    if (bank_rst_w) begin
      pos_x_q <= `JSR_RST_POS_THR;
      neg_x_q <= `JSR_RST_NEG_THR;
      pos_y_q <= `JSR_RST_POS_THR;
      neg_y_q <= `JSR_RST_NEG_THR;
    end else if (wr_stb_w) begin
      if (ptr_q == `JSR_ADDR_POS_X) pos_x_q <= sh_q;
      if (ptr_q == `JSR_ADDR_NEG_X) neg_x_q <= sh_q;
      if (ptr_q == `JSR_ADDR_POS_Y) pos_y_q <= sh_q;
      if (ptr_q == `JSR_ADDR_NEG_Y) neg_y_q <= sh_q;
    end
  end

  // results, valid flag and interrupt; a new event wins over a Y read or calc start clear but not over the mask, and hard or soft reset wins over a new event
  always_ff @(posedge i_core_clk) begin
    if (bank_rst_w) begin
      x_res_q <= `JSR_RST_RESULT;
      y_res_q <= `JSR_RST_RESULT;
      ch4m_q <= `JSR_RST_VOLT;
      ch4p_q <= `JSR_RST_VOLT;
      valid_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      if (i_xy_new) begin
        x_res_q <= i_x_coord;
        y_res_q <= i_y_coord;
        ch4m_q <= i_ch4_minus;
        ch4p_q <= i_ch4_plus;
      end
      if (i_xy_new) valid_q <= 1'b1;
      else if (i_calc_start) valid_q <= 1'b0;
      if (irq_set_w) irq_n_q <= 1'b0;
      else if (irq_clr_w) irq_n_q <= 1'b1;
    end
  end

  assign o_sda_out = sda_out_q;
  assign o_sda_oe = sda_oe_q;
  assign o_idle_mode = idle_q;
  assign o_timebase = tb_q;
  assign o_motion_irq_n = irq_n_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence addr_match_s;
    scl_fall_w && state_q == JSR_ADDR && byte_full_w && sh_q[7:1] == DEV_ADDR;
  endsequence
  sequence ack_driven_s;
    o_sda_oe && state_q == JSR_ADDR_ACK;
  endsequence
  sequence load_ctrl_s;
    rd_load_w && ptr_q == `JSR_ADDR_CTRL;
  endsequence

  addr_ack_a: assert property (addr_match_s |=> ack_driven_s)
    else $error("address match not acknowledged");
  ctrl_read_a: assert property (load_ctrl_s |=>
      tx_q == {idle_q, tb_q, mask_q, cond_q, 1'b0, valid_q} || $past(i_xy_new) ||
      $past(i_calc_start))
    else $error("control readback wrong");
  idle_write_a: assert property (wr_ctrl_w && !sh_q[`JSR_CTRL_SRST] |=>
      o_idle_mode == $past(sh_q[`JSR_CTRL_IDLE]) &&
      o_timebase == $past(sh_q[`JSR_CTRL_TB_HI:`JSR_CTRL_TB_LO]))
    else $error("idle or time base not written");
  soft_reset_a: assert property (soft_w |=> o_idle_mode && o_timebase == `JSR_RST_TIMEBASE &&
      !mask_q && !cond_q && pos_x_q == `JSR_RST_POS_THR && neg_y_q == `JSR_RST_NEG_THR &&
      x_res_q == `JSR_RST_RESULT && o_motion_irq_n)
    else $error("soft reset left a register");
  mask_hold_a: assert property (mask_q && o_motion_irq_n |=> o_motion_irq_n)
    else $error("masked interrupt asserted");
  every_pair_a: assert property (i_xy_new && !mask_q && !cond_q && !soft_w
      |=> !o_motion_irq_n)
    else $error("new pair did not raise interrupt");
  window_irq_a: assert property (i_xy_new && !mask_q && cond_q && !soft_w &&
      !rd_y_w && !outside_w && o_motion_irq_n |=> o_motion_irq_n)
    else $error("inside window raised interrupt");
  valid_flag_a: assert property (i_calc_start && !i_xy_new && !soft_w
      |=> !valid_q ##1 (valid_q || !$past(i_xy_new)))
    else $error("valid flag wrong");
  result_latch_a: assert property (i_xy_new && !soft_w |=>
      x_res_q == $past(i_x_coord) && y_res_q == $past(i_y_coord))
    else $error("result not latched");
  y_clear_a: assert property (rd_y_w && !i_xy_new |=> o_motion_irq_n)
    else $error("y read did not clear interrupt");
  thr_write_a: assert property (wr_stb_w && ptr_q == `JSR_ADDR_NEG_X
      |=> neg_x_q == $past(sh_q))
    else $error("threshold not written");
  volt_sign_a: assert property (rd_load_w && ptr_q == `JSR_ADDR_CH4M_HI
      |=> tx_q[7:4] == {4{$past(ch4m_q[11])}} && tx_q[3:0] == $past(ch4m_q[11:8]))
    else $error("voltage high byte not sign extended");
  id_read_a: assert property (rd_load_w && ptr_q == `JSR_ADDR_MAKER
      |=> tx_q == MAKER_ID)
    else $error("maker code wrong");
  irq_hold_a: assert property (!o_motion_irq_n && !rd_y_w && !soft_w && !mask_q
      |=> !o_motion_irq_n)
    else $error("interrupt released early");
endmodule : jsr_register_bank

//--- test/jsr_i2c_host.sv
/*
  Two-wire bus host model driving the register bank's serial port.
  Assumes an SDA pull-up resolved by the bench; half sets the phase length.
*/
`timescale 1ns/10ps
module jsr_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // clock
  input wire logic i_core_clk,
  // bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  int half = 10;
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  // data moves mid low phase, clear of both scl edges
  task automatic put_bit(input logic b, output logic r);
    step(half / 2);
    o_sda_pull = ~b;
    step(half - half / 2);
    o_scl = 1'b1;
    step(half / 2);
    r = i_sda;
    step(half - half / 2);
    o_scl = 1'b0;
  endtask : put_bit
  task automatic start();
    step(half);
    o_sda_pull = 1'b1;
    step(half);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    step(half / 2);
    o_sda_pull = 1'b1;
    step(half - half / 2);
    o_scl = 1'b1;
    step(half);
    o_sda_pull = 1'b0;
    step(half);
  endtask : stop
  // ninth bit: last=1 releases the line so the device may acknowledge
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
      q[i] = r;
    end
    put_bit(last, r);
    ack = ~r;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    xfer(d, 1'b1, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[16],
                    output logic ok);
    logic [7:0] dmy;
    logic k0, k1, k2, kx;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, dmy, k0);
    xfer(a, 1'b1, dmy, k1);
    stop();
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, dmy, k2);
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, q[i], kx);
    end
    stop();
    ok = k0 & k1 & k2;
  endtask : rd
endmodule : jsr_i2c_host

//--- test/tb_top.sv
/*
  Self-checking bench for the joystick sensor register bank.
  Assumes jsr_pkg and the host model are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import jsr_pkg::*;
  localparam logic [6:0] DEV = 7'h31; // arbitrary value
  localparam logic [7:0] MAKER = 8'h4e; // arbitrary value
  localparam logic [7:0] VER = 8'h17; // arbitrary value
  localparam logic [7:0] SIREV = 8'h09; // arbitrary value
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic scl, sda_pull, sda_line, o_sda_out, o_sda_oe, o_idle_mode, o_motion_irq_n;
  logic [2:0] o_timebase;
  logic xy_new = 1'b0;
  logic calc_start = 1'b0;
  jsr_coord_t x_coord = 8'h00;
  jsr_coord_t y_coord = 8'h00;
  jsr_volt_t v_minus = 12'h000;
  jsr_volt_t v_plus = 12'h000;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h0348;
  int px[8] = '{5, 6, -5, -6, 0, 0, 0, 0};
  int py[8] = '{0, 0, 0, 0, 5, 6, -5, -6};
  // model state
  logic [7:0] m_ctrl;
  int m_valid, m_pend, m_x, m_y, m_vm, m_vp;
  int m_thr[4];
  always #20 i_core_clk = ~i_core_clk;
  // pull-up: low only while a party pulls
  assign sda_line = !((o_sda_oe && !o_sda_out) || sda_pull);
  jsr_register_bank #(.DEV_ADDR(DEV), .MAKER_ID(MAKER), .VERSION_ID(VER),
                      .SIREV_ID(SIREV)) i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_xy_new(xy_new),
    .i_calc_start(calc_start), .i_x_coord(x_coord), .i_y_coord(y_coord),
    .i_ch4_minus(v_minus), .i_ch4_plus(v_plus), .o_idle_mode(o_idle_mode),
    .o_timebase(o_timebase), .o_motion_irq_n(o_motion_irq_n));
  jsr_i2c_host #(.DEV_ADDR(DEV)) i_host (
    .i_core_clk(i_core_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(sda_pull));
  task automatic end_of_test();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic model_reset();
    m_ctrl = 8'hf0;
    m_valid = 0;
    m_pend = 0;
    m_x = 0;
    m_y = 0;
    m_vm = 0;
    m_vp = 0;
    m_thr = '{5, -5, 5, -5};
  endtask : model_reset
  function automatic logic [7:0] exp_byte(input int a);
    case (a)
      8'h0c: return MAKER;
      8'h0d: return VER;
      8'h0e: return SIREV;
      8'h0f: return m_ctrl | 8'(m_valid);
      8'h10: return 8'(m_x);
      8'h11: return 8'(m_y);
      8'h12, 8'h13, 8'h14, 8'h15: return 8'(m_thr[a - 8'h12]);
      8'h16: return 8'(m_vm >>> 8);
      8'h17: return 8'(m_vm);
      8'h18: return 8'(m_vp >>> 8);
      8'h19: return 8'(m_vp);
      default: return 8'h00;
    endcase
  endfunction : exp_byte
  task automatic rdn(input logic [7:0] a, input int n);
    logic [7:0] q[16];
    logic ok;
    i_host.rd(a, n, q, ok);
    `CHK(ok, 1'b1)
    for (int i = 0; i < n; i++) begin
      `CHK(q[i], exp_byte(a + i))
      if (a + i == 8'h11) m_pend = 0;
    end
    `CHK(o_motion_irq_n, 1'(m_pend == 0))
  endtask : rdn
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_host.wr(a, d, ok);
    `CHK(ok, 1'b1)
    if (a == 8'h0f && d[1]) begin
      model_reset();
    end else if (a == 8'h0f) begin
      m_ctrl = d & 8'hfc;
      if (d[3]) m_pend = 0;
    end else if (a >= 8'h12 && a <= 8'h15) begin
      m_thr[a - 8'h12] = int'($signed(d));
    end
    `CHK(o_motion_irq_n, 1'(m_pend == 0))
    `CHK(o_idle_mode, m_ctrl[7])
    `CHK(o_timebase, m_ctrl[6:4])
  endtask : wr
  // two data bytes in one frame: the pointer steps after each byte
  task automatic burst(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    i_host.start();
    i_host.xfer({DEV, 1'b0}, 1'b1, q, k0);
    i_host.xfer(a, 1'b1, q, k1);
    i_host.xfer(d0, 1'b1, q, k2);
    i_host.xfer(d1, 1'b1, q, k3);
    i_host.stop();
    `CHK(k0 & k1 & k2 & k3, 1'b1)
    m_thr[a - 8'h12] = int'($signed(d0));
    m_thr[a - 8'h11] = int'($signed(d1));
  endtask : burst
  task automatic meas(input int x, input int y);
    int vm;
    int vp;
    vm = $random(seed) % 2048;
    vp = $random(seed) % 2048;
    @(posedge i_core_clk);
    #1;
    xy_new = 1'b1;
    x_coord = 8'(x);
    y_coord = 8'(y);
    v_minus = 12'(vm);
    v_plus = 12'(vp);
    @(posedge i_core_clk);
    #1;
    xy_new = 1'b0;
    m_x = x;
    m_y = y;
    m_vm = vm;
    m_vp = vp;
    m_valid = 1;
    if (!m_ctrl[3] && (!m_ctrl[2] || x > m_thr[0] || x < m_thr[1] || y > m_thr[2] ||
        y < m_thr[3])) m_pend = 1;
    `CHK(o_motion_irq_n, 1'(m_pend == 0))
  endtask : meas
  task automatic calc();
    @(posedge i_core_clk);
    #1;
    calc_start = 1'b1;
    @(posedge i_core_clk);
    #1;
    calc_start = 1'b0;
    m_valid = 0;
  endtask : calc
  initial begin
    repeat (100000) @(posedge i_core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] q;
    logic ack;
    model_reset();
    repeat (12) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1;
    rdn(8'h0c, 15);
    // read-only and unmapped writes must vanish
    wr(8'h10, 8'h77);
    wr(8'h0d, 8'h00);
    wr(8'h1a, 8'h33);
    for (int i = 0; i < 4; i++) begin
      wr(8'h12 + 8'(i), 8'($random(seed)));
    end
    i_host.half = 24;
    rdn(8'h0c, 15);
    i_host.half = 10;
    meas($random(seed) % 128, $random(seed) % 128);
    rdn(8'h0f, 2);
    calc();
    rdn(8'h0f, 1);
    meas(-127, 127);
    burst(8'h12, 8'($random(seed)), 8'($random(seed)));
    rdn(8'h10, 10);
    // window condition, strict boundaries then random points
    wr(8'h0f, 8'h34);
    for (int i = 0; i < 4; i++) begin
      wr(8'h12 + 8'(i), i[0] ? 8'hfb : 8'h05);
    end
    for (int i = 0; i < 16; i++) begin
      if (i < 8) meas(px[i], py[i]);
      else meas($random(seed) % 10, $random(seed) % 10);
      rdn(8'h11, 1);
    end
    // masking releases a pending request and blocks new ones
    wr(8'h0f, 8'h30);
    meas(1, 1);
    wr(8'h0f, 8'h38);
    meas(2, 2);
    wr(8'h0f, 8'h30);
    meas(3, -3);
    wr(8'h14, 8'h22);
    wr(8'h0f, 8'h06);
    rdn(8'h0c, 15);
    // foreign address gets no acknowledge
    i_host.start();
    i_host.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, q, ack);
    i_host.stop();
    `CHK(ack, 1'b0)
    rdn(8'h0f, 1);
    end_of_test();
  end
endmodule : tb_top
